// ==== test/ardp_datapath_checker.sv ====
// Concurrent checks on the arithmetic register datapath ports
`timescale 1ns/1ps
`default_nettype none
module ardp_datapath_checker
  import ardp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire ardp_cmd_e cmd_code,
  input wire logic [1:0] jump_cond,
  input wire logic [47:0] mem_word,
  input wire logic [14:0] prog_addr,
  input wire logic [14:0] address_accumulator,
  input wire logic busy,
  input wire logic [47:0] acc,
  input wire logic [47:0] aux_first,
  input wire logic [47:0] aux_second,
  input wire logic [47:0] xchg_first,
  input wire logic [47:0] xchg_second,
  input wire logic [47:0] stage_word,
  input wire logic stage_valid,
  input wire logic jump_taken,
  input wire logic op_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Commands offered while busy are dropped, so only idle strobes count
  wire logic take = cmd_valid && !busy;
  wire logic [10:0] exp_bits = address_accumulator[10:0];
  sequence took(ardp_cmd_e c);
    take && cmd_code == c;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_aux_from_acc: assert property (took(CMD_ACC_TO_AUX) |=> aux_first == $past(acc))
    else $error("aux did not copy acc");
  a_sel_sub_mix: assert property (took(CMD_SEL_SUB) |=>
    acc == (($past(acc) & ~$past(aux_first)) | ($past(mem_word) & $past(aux_first))))
    else $error("selective substitute wrong");
  a_xchg_cleared_load: assert property (took(CMD_MEM_TO_XCHG) |=> xchg_first == $past(mem_word))
    else $error("exchange load kept old ones");
  a_rni_clears_xchg: assert property (took(CMD_RNI_CLEAR) |=> xchg_first == WORD_ZERO)
    else $error("exchange not cleared");
  a_addr_low_xchg: assert property (took(CMD_ADDR_TO_XCHG) |=>
    xchg_first == {33'h0_0000_0000, $past(address_accumulator)})
    else $error("address not in exchange low part");
  a_exp_field_move: assert property (took(CMD_EXP_TO_XCHG) |=> xchg_first[46:36] == $past(exp_bits))
    else $error("exponent field wrong");
  a_ret_jump_addr: assert property (took(CMD_RET_JUMP) |=> xchg_second[14:0] == $past(prog_addr))
    else $error("return address not in second rank");
  a_aux_rank_move: assert property (took(CMD_AUX2_TO_AUX1) |=> aux_first == $past(aux_second))
    else $error("aux second rank not moved");
  a_stage_aux_kept: assert property (stage_valid && $past(busy) |->
    stage_word == aux_first && $stable(aux_first))
    else $error("staged word differs from aux");
  a_done_ends_busy: assert property (op_done |-> !busy && $past(busy))
    else $error("done without a finished run");
  a_jump_on_zero: assert property (take && cmd_code == CMD_ACC_JUMP && jump_cond == JC_ZERO |=>
    jump_taken == (($past(acc) == WORD_ZERO) || ($past(acc) == ~WORD_ZERO)))
    else $error("zero jump decision wrong");
  c_done: cover property (op_done);
  c_stage: cover property (stage_valid);
  c_jump: cover property (jump_taken);
endmodule : ardp_datapath_checker
`default_nettype wire

// ==== test/ardp_datapath_tb.sv ====
// Self-checking bench for the arithmetic register datapath
`timescale 1ns/1ps
`default_nettype none
module ardp_datapath_tb
  import ardp_pkg::*;
;
  logic ref_clk, rst_b, cmd_valid, busy, stage_valid, jump_taken, search_hit, op_done;
  ardp_cmd_e cmd_code;
  logic [14:0] cmd_count, addr_in, prog_addr, address_accumulator, addr_buffer, aw, pw;
  logic [47:0] mem_word, in_word, acc, aux_first, aux_second, xchg_first, xchg_second;
  logic [47:0] stage_word, staged, mw, iw, ea, eq;
  logic [1:0] jump_cond, jw;
  int failures, n_tests, n_staged, cyc;
  ardp_datapath dut (.ref_clk, .rst_b, .cmd_valid, .cmd_code, .cmd_count, .jump_cond,
    .mem_word, .in_word, .addr_in, .prog_addr, .busy, .acc, .aux_first, .aux_second,
    .xchg_first, .xchg_second, .address_accumulator, .addr_buffer, .stage_word,
    .stage_valid, .jump_taken, .search_hit, .op_done);
  ardp_store_model u_store (.ref_clk, .rst_b, .stage_word, .stage_valid, .staged, .n_staged);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // A hung handshake must still reach the verdict
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic issue(input ardp_cmd_e c, input logic [14:0] n = 15'h0000);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_count <= n;
    mem_word <= mw;
    in_word <= iw;
    addr_in <= aw;
    prog_addr <= pw;
    jump_cond <= jw;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask : issue
  task automatic wait_done();
    int k;
    k = 0;
    while (op_done !== 1'b1 && k < 200) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk("op_done", 48'h0000_0000_0001, {47'h0, op_done});
  endtask : wait_done
  task automatic do_reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    ea = 48'h0000_0000_0000;
    eq = 48'h0000_0000_0000;
  endtask : do_reset
  function automatic logic [47:0] oc_add(input logic [47:0] a, input logic [47:0] b);
    logic [48:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[47:0] + {47'h0, s[48]};
  endfunction : oc_add
  // Accumulator has no direct load, so words come in through the exchange
  task automatic load_acc(input logic [47:0] w);
    mw = w;
    issue(CMD_MEM_TO_XCHG);
    issue(CMD_XCHG1_TO_XCHG2);
    issue(CMD_ADD_XCHG2);
    ea = oc_add(ea, w);
    chk("acc_add", ea, acc);
  endtask : load_acc
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_shift();
    do_reset();
    load_acc(48'h0812_3456_789a);
    issue(CMD_SHL_ACC, 15'h0004);
    wait_done();
    ea = {ea[43:0], ea[47:44]};
    chk("acc_shl", ea, acc);
    chk("count_end", 48'h0000_0000_0000, {33'h0, addr_buffer});
    issue(CMD_SHR_ACC, 15'h0003);
    wait_done();
    ea = $signed(ea) >>> 3;
    chk("acc_shr", ea, acc);
    for (int j = 0; j < 4; j++) begin
      jw = j[1:0];
      issue(CMD_ACC_JUMP);
      chk("jump", {47'h0, j[0]}, {47'h0, jump_taken});
    end
  endtask : t_shift
  task automatic t_dbl();
    do_reset();
    load_acc(48'h8123_4567_89ab);
    issue(CMD_ACC_TO_AUX);
    eq = ea;
    chk("aux_copy", eq, aux_first);
    load_acc(48'h1000_0000_0003);
    issue(CMD_SHL_DBL, 15'h0002);
    wait_done();
    issue(CMD_AUX2_TO_AUX1);
    {ea, eq} = {ea[45:0], eq, ea[47:46]};
    chk("dbl_shl_hi", ea, acc);
    chk("dbl_shl_lo", eq, aux_first);
    issue(CMD_SHR_DBL, 15'h0002);
    wait_done();
    issue(CMD_AUX2_TO_AUX1);
    {ea, eq} = $signed({ea, eq}) >>> 2;
    chk("dbl_shr_hi", ea, acc);
    chk("dbl_shr_lo", eq, aux_first);
    issue(CMD_STORE_AUX);
    wait_done();
    @(posedge ref_clk);
    #1;
    chk("staged", eq, staged);
    chk("n_staged", 48'h0000_0000_0001, {16'h0, n_staged});
    chk("aux_kept", eq, aux_first);
    chk("acc_kept", ea, acc);
    mw = 48'hffff_0000_ffff;
    issue(CMD_SEL_SUB);
    ea = (ea & ~eq) | (mw & eq);
    chk("sel_sub", ea, acc);
  endtask : t_dbl
  task automatic t_xchg();
    iw = 48'h0f0f_1234_0000;
    issue(CMD_MEM_TO_XCHG);
    chk("x_mem", mw, xchg_first);
    issue(CMD_IN_TO_XCHG);
    chk("x_in", iw, xchg_first);
    issue(CMD_MEM_TO_XCHG);
    issue(CMD_BUF_IO);
    chk("buf_addr", {33'h0, mw[14:0]}, {33'h0, addr_buffer});
    issue(CMD_RNI_CLEAR);
    chk("x_rni", 48'h0000_0000_0000, xchg_first);
    aw = 15'h0c5c;
    issue(CMD_LOAD_ADDR);
    issue(CMD_ADDR_TO_XCHG);
    chk("x_addr", {33'h0, aw}, xchg_first);
    issue(CMD_STORE_ACC);
    @(posedge ref_clk);
    #1;
    chk("st_x", {33'h0, aw}, staged);
    issue(CMD_EXP_TO_XCHG);
    chk("x_exp", {37'h0, aw[10:0]}, {37'h0, xchg_first[46:36]});
    aw = 15'h0000;
    issue(CMD_LOAD_ADDR);
    issue(CMD_XCHG_TO_EXP);
    chk("exp_back", 48'h0000_0000_7c5c, {33'h0, address_accumulator});
    pw = 15'h1234;
    issue(CMD_RET_JUMP);
    chk("ret_addr", {33'h0, pw}, {33'h0, xchg_second[14:0]});
  endtask : t_xchg
  task automatic t_mul();
    do_reset();
    load_acc(48'h0000_0000_0005);
    issue(CMD_ACC_TO_AUX);
    mw = 48'h0000_0000_0007;
    issue(CMD_MEM_TO_XCHG);
    issue(CMD_XCHG1_TO_XCHG2);
    issue(CMD_MULTIPLY, 15'h0030);
    issue(CMD_RNI_CLEAR);
    wait_done();
    chk("x_kept", mw, xchg_first);
    chk("prod_hi", 48'h0000_0000_0000, acc);
    chk("prod_lo", 48'h0000_0000_0023, aux_first);
    issue(CMD_DIVIDE, 15'h0030);
    wait_done();
    chk("quot", 48'h0000_0000_0005, aux_first);
    chk("rem", 48'h0000_0000_0000, acc);
    for (int j = 0; j < 2; j++) begin
      mw = j[0] ? 48'h0000_0000_0002 : 48'h0000_0000_0004;
      issue(CMD_MASK_EQ);
      chk("eq_hit", {47'h0, j[0]}, {47'h0, search_hit});
      issue(CMD_MASK_THR);
      chk("thr_hit", {47'h0, !j[0]}, {47'h0, search_hit});
    end
  endtask : t_mul
  task automatic test_done();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = CMD_NOP;
    cmd_count = 15'h0000;
    {addr_in, prog_addr, aw, pw} = 60'h0;
    {mem_word, in_word, mw, iw} = 192'h0;
    {jump_cond, jw} = 4'h0;
    t_shift();
    t_dbl();
    t_xchg();
    t_mul();
    test_done();
  end
endmodule : ardp_datapath_tb
bind ardp_datapath ardp_datapath_checker u_chk (.ref_clk, .rst_b, .cmd_valid, .cmd_code,
  .jump_cond, .mem_word, .prog_addr, .address_accumulator, .busy, .acc, .aux_first,
  .aux_second, .xchg_first, .xchg_second, .stage_word, .stage_valid, .jump_taken, .op_done);
`default_nettype wire

// ==== test/ardp_store_model.sv ====
// Write staging model that captures words offered for storage
`timescale 1ns/1ps
`default_nettype none
module ardp_store_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [47:0] stage_word,
  input wire logic stage_valid,
  output logic [47:0] staged,
  output var int n_staged
);
  // A word counts as written only on the cycle its strobe is high
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      staged <= 48'h0000_0000_0000;
      n_staged <= 0;
    end else if (stage_valid) begin
      staged <= stage_word;
      n_staged <= n_staged + 1;
    end
  end
endmodule : ardp_store_model
`default_nettype wire

// ==== verilog/ardp_datapath.sv ====
// Arithmetic register datapath: accumulator, auxiliary and exchange registers
`timescale 1ns/1ps
`default_nettype none
module ardp_datapath
  import ardp_pkg::*;
#(
  parameter int W = WORD_W,
  parameter int AW = ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire ardp_cmd_e cmd_code,
  input wire logic [AW-1:0] cmd_count,
  input wire logic [1:0] jump_cond,
  input wire logic [W-1:0] mem_word,
  input wire logic [W-1:0] in_word,
  input wire logic [AW-1:0] addr_in,
  input wire logic [AW-1:0] prog_addr,
  output logic busy,
  output logic [W-1:0] acc,
  output logic [W-1:0] aux_first,
  output logic [W-1:0] aux_second,
  output logic [W-1:0] xchg_first,
  output logic [W-1:0] xchg_second,
  output logic [AW-1:0] address_accumulator,
  output logic [AW-1:0] addr_buffer,
  output logic [W-1:0] stage_word,
  output logic stage_valid,
  output logic jump_taken,
  output logic search_hit,
  output logic op_done
);

  ardp_state_e state_reg;
  ardp_state_e state_next;
  logic [W-1:0] acc_save_reg;
  logic [W-1:0] mag_reg;
  logic neg_reg;
  logic [2:0] store_step_reg;
  logic shift_left_reg;
  logic shift_dbl_reg;
  logic go;
  logic step_end;
  logic [W:0] mul_sum;
  logic [W:0] div_rem;
  logic [W:0] div_diff;
  logic acc_is_zero;

  ////////////////////////////////////////////////////////////////////////////
  // Ones' complement add with end-around carry
  function automatic logic [W-1:0] oc_add(input logic [W-1:0] a, input logic [W-1:0] b);
    logic [W:0] s;
    s = {1'b0, a} + {1'b0, b};
    oc_add = s[W-1:0] + {{(W-1){1'b0}}, s[W]};
  endfunction : oc_add

  // Commands are only taken while idle; later ones must wait for busy to drop
  assign go = cmd_valid && (state_reg == ST_IDLE);
  assign step_end = (addr_buffer == ADDR_ZERO);
  assign mul_sum = {1'b0, acc} + (aux_first[0] ? {1'b0, mag_reg} : {1'b0, WORD_ZERO});
  assign div_rem = {acc, aux_first[W-1]};
  assign div_diff = div_rem - {1'b0, mag_reg};
  // Both all-zeros and all-ones are zero in ones' complement
  assign acc_is_zero = (acc == WORD_ZERO) || (acc == ~WORD_ZERO);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go) begin
          case (cmd_code)
            CMD_SHL_ACC, CMD_SHR_ACC, CMD_SHL_DBL, CMD_SHR_DBL: state_next = ST_SHIFT;
            CMD_MULTIPLY: state_next = ST_MUL;
            CMD_DIVIDE: state_next = ST_DIV;
            CMD_STORE_AUX: state_next = ST_STORE;
            default: state_next = ST_IDLE;
          endcase
        end
      end
      ST_SHIFT: begin
        if (step_end) begin
          state_next = ST_IDLE;
        end
      end
      ST_MUL, ST_DIV: begin
        if (step_end) begin
          state_next = ST_FIX;
        end
      end
      ST_FIX: state_next = ST_IDLE;
      ST_STORE: begin
        if (store_step_reg == STORE_LAST) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      busy <= 1'b0;
      op_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy <= (state_next != ST_IDLE);
      op_done <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      shift_left_reg <= 1'b0;
      shift_dbl_reg <= 1'b0;
      neg_reg <= 1'b0;
      mag_reg <= WORD_ZERO;
      store_step_reg <= STORE_FIRST;
    end else begin
      if (go) begin
        shift_left_reg <= (cmd_code == CMD_SHL_ACC) || (cmd_code == CMD_SHL_DBL);
        shift_dbl_reg <= (cmd_code == CMD_SHL_DBL) || (cmd_code == CMD_SHR_DBL);
        // Divisor or multiplicand comes from the exchange second rank
        mag_reg <= xchg_second[SIGN_BIT] ? ~xchg_second : xchg_second;
        if (cmd_code == CMD_MULTIPLY) begin
          neg_reg <= aux_first[SIGN_BIT] ^ xchg_second[SIGN_BIT];
        end else begin
          neg_reg <= acc[SIGN_BIT] ^ xchg_second[SIGN_BIT];
        end
      end
      if (state_reg == ST_STORE) begin
        store_step_reg <= store_step_reg + 3'h1;
      end else begin
        store_step_reg <= STORE_FIRST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address buffer: step counter, shift counter and buffer address
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      addr_buffer <= ADDR_ZERO;
    end else if (go) begin
      case (cmd_code)
        CMD_SHL_ACC, CMD_SHR_ACC, CMD_SHL_DBL, CMD_SHR_DBL,
        CMD_MULTIPLY, CMD_DIVIDE: addr_buffer <= cmd_count;
        CMD_BUF_IO: addr_buffer <= mem_word[AW-1:0];
        default: addr_buffer <= addr_buffer;
      endcase
    end else if (((state_reg == ST_SHIFT) || (state_reg == ST_MUL) ||
                  (state_reg == ST_DIV)) && !step_end) begin
      addr_buffer <= addr_buffer - ADDR_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      acc <= WORD_ZERO;
      acc_save_reg <= WORD_ZERO;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            case (cmd_code)
              CMD_SEL_SUB: acc <= (acc & ~aux_first) | (mem_word & aux_first);
              CMD_ADD_XCHG2: acc <= oc_add(acc, xchg_second);
              CMD_MULTIPLY: acc <= WORD_ZERO;
              CMD_DIVIDE: acc <= acc[SIGN_BIT] ? ~acc : acc;
              CMD_STORE_AUX: acc_save_reg <= acc;
              default: acc <= acc;
            endcase
          end
        end
        ST_SHIFT: begin
          if (!step_end) begin
            if (shift_left_reg) begin
              // Bit 47 wraps to bit 0 alone, or via the auxiliary when paired
              acc <= {acc[W-2:0], shift_dbl_reg ? aux_second[W-1] : acc[W-1]};
            end else begin
              acc <= {acc[W-1], acc[W-1:1]};
            end
          end
        end
        ST_MUL: begin
          if (!step_end) begin
            acc <= mul_sum[W:1];
          end
        end
        ST_DIV: begin
          if (!step_end) begin
            acc <= div_diff[W] ? div_rem[W-1:0] : div_diff[W-1:0];
          end
        end
        ST_FIX: begin
          if (neg_reg) begin
            acc <= ~acc;
          end
        end
        ST_STORE: begin
          if (store_step_reg == STORE_LOAD_ACC) begin
            acc <= aux_second;
          end else if (store_step_reg == STORE_TO_XCHG) begin
            acc <= acc_save_reg;
          end
        end
        default: acc <= acc;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auxiliary register, two ranks moved only on command
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      aux_first <= WORD_ZERO;
      aux_second <= WORD_ZERO;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            case (cmd_code)
              CMD_ACC_TO_AUX: aux_first <= acc;
              CMD_AUX2_TO_AUX1: aux_first <= aux_second;
              CMD_AUX1_TO_AUX2: aux_second <= aux_first;
              CMD_SHL_DBL, CMD_SHR_DBL: aux_second <= aux_first;
              CMD_MULTIPLY: aux_first <= aux_first[SIGN_BIT] ? ~aux_first : aux_first;
              CMD_DIVIDE: aux_first <= acc[SIGN_BIT] ? ~aux_first : aux_first;
              default: aux_first <= aux_first;
            endcase
          end
        end
        ST_SHIFT: begin
          // Each double-shift step shifts the second rank, so multi-place shifts stay chained
          if (!step_end && shift_dbl_reg) begin
            if (shift_left_reg) begin
              aux_second <= {aux_second[W-2:0], acc[W-1]};
            end else begin
              aux_second <= {acc[0], aux_second[W-1:1]};
            end
          end
        end
        ST_MUL: begin
          if (!step_end) begin
            aux_first <= {mul_sum[0], aux_first[W-1:1]};
          end
        end
        ST_DIV: begin
          if (!step_end) begin
            aux_first <= {aux_first[W-2:0], ~div_diff[W]};
          end
        end
        ST_FIX: begin
          if (neg_reg) begin
            aux_first <= ~aux_first;
          end
        end
        ST_STORE: begin
          if (store_step_reg == STORE_FIRST) begin
            aux_second <= aux_first;
          end
        end
        default: aux_first <= aux_first;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exchange register; loaded from the mem_word, in_word and prog_addr ports and from internal paths
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      xchg_first <= WORD_ZERO;
      xchg_second <= WORD_ZERO;
    end else if (go) begin
      // Each first-rank load starts from a cleared rank, so unused bits read 0
      case (cmd_code)
        CMD_MEM_TO_XCHG, CMD_BUF_IO: xchg_first <= WORD_ZERO | mem_word;
        CMD_ACC_TO_XCHG: xchg_first <= WORD_ZERO | acc;
        CMD_IN_TO_XCHG: xchg_first <= WORD_ZERO | in_word;
        CMD_RNI_CLEAR: xchg_first <= WORD_ZERO;
        CMD_EXP_TO_XCHG: begin
          xchg_first <= WORD_ZERO |
            ({{(W-EXP_W){1'b0}}, address_accumulator[EXP_W-1:0]} << EXP_LSB);
        end
        CMD_ADDR_TO_XCHG: xchg_first <= WORD_ZERO | {{(W-AW){1'b0}}, address_accumulator};
        CMD_RET_JUMP: xchg_second <= {{(W-AW){1'b0}}, prog_addr};
        CMD_XCHG1_TO_XCHG2: xchg_second <= xchg_first;
        default: xchg_first <= xchg_first;
      endcase
    end else if ((state_reg == ST_STORE) && (store_step_reg == STORE_TO_XCHG)) begin
      xchg_first <= WORD_ZERO | acc;
    end
  end

  // Write staging sees the exchange first rank one cycle after it is set up
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stage_word <= WORD_ZERO;
      stage_valid <= 1'b0;
    end else begin
      stage_valid <= 1'b0;
      if ((state_reg == ST_STORE) && (store_step_reg == STORE_LAST)) begin
        stage_word <= xchg_first;
        stage_valid <= 1'b1;
      end else if (go && (cmd_code == CMD_STORE_ACC)) begin
        stage_word <= xchg_first;
        stage_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address accumulator: exponent and address words
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      address_accumulator <= ADDR_ZERO;
    end else if (go) begin
      case (cmd_code)
        CMD_XCHG_TO_EXP: begin
          // Sign of the 11-bit exponent is extended across the 15-bit word
          address_accumulator <= {{(AW-EXP_W){xchg_first[EXP_LSB+EXP_W-1]}},
                                  xchg_first[EXP_LSB +: EXP_W]};
        end
        CMD_LOAD_ADDR: address_accumulator <= addr_in;
        default: address_accumulator <= address_accumulator;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition tests: accumulator jump and masked searches
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      jump_taken <= 1'b0;
      search_hit <= 1'b0;
    end else begin
      jump_taken <= 1'b0;
      search_hit <= 1'b0;
      if (go && (cmd_code == CMD_ACC_JUMP)) begin
        case (jump_cond)
          JC_ZERO: jump_taken <= acc_is_zero;
          JC_NONZERO: jump_taken <= !acc_is_zero;
          JC_POS: jump_taken <= !acc[SIGN_BIT];
          JC_NEG: jump_taken <= acc[SIGN_BIT];
          default: jump_taken <= 1'b0;
        endcase
      end
      if (go && (cmd_code == CMD_MASK_EQ)) begin
        search_hit <= (((mem_word ^ acc) & aux_first) == WORD_ZERO);
      end
      if (go && (cmd_code == CMD_MASK_THR)) begin
        // Masked fields compared as plain magnitudes
        search_hit <= ((mem_word & aux_first) > (acc & aux_first));
      end
    end
  end

endmodule : ardp_datapath
`default_nettype wire

// ==== verilog/ardp_pkg.sv ====
// Constants, command codes and states of the arithmetic register datapath
package ardp_pkg;
  localparam int WORD_W = 48;
  localparam int ADDR_W = 15;
  localparam int EXP_W = 11;
  localparam int EXP_LSB = 36;
  localparam int SIGN_BIT = WORD_W - 1;
  localparam logic [WORD_W-1:0] WORD_ZERO = 48'h0000_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;
  localparam logic [2:0] STORE_LAST = 3'h3;
  localparam logic [2:0] STORE_FIRST = 3'h0;
  localparam logic [2:0] STORE_LOAD_ACC = 3'h1;
  localparam logic [2:0] STORE_TO_XCHG = 3'h2;
  localparam logic [1:0] JC_ZERO = 2'h0;
  localparam logic [1:0] JC_NONZERO = 2'h1;
  localparam logic [1:0] JC_POS = 2'h2;
  localparam logic [1:0] JC_NEG = 2'h3;

  typedef enum logic [4:0] {
    CMD_NOP, CMD_SHL_ACC, CMD_SHR_ACC, CMD_SHL_DBL, CMD_SHR_DBL,
    CMD_AUX2_TO_AUX1, CMD_AUX1_TO_AUX2, CMD_ACC_TO_AUX, CMD_STORE_AUX,
    CMD_SEL_SUB, CMD_MEM_TO_XCHG, CMD_ACC_TO_XCHG, CMD_IN_TO_XCHG,
    CMD_RNI_CLEAR, CMD_EXP_TO_XCHG, CMD_XCHG_TO_EXP, CMD_ADDR_TO_XCHG,
    CMD_BUF_IO, CMD_RET_JUMP, CMD_XCHG1_TO_XCHG2, CMD_ADD_XCHG2,
    CMD_MULTIPLY, CMD_DIVIDE, CMD_MASK_EQ, CMD_MASK_THR, CMD_ACC_JUMP,
    CMD_LOAD_ADDR, CMD_STORE_ACC
  } ardp_cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SHIFT, ST_MUL, ST_DIV, ST_FIX, ST_STORE
  } ardp_state_e;
endpackage : ardp_pkg
